// ### src/drfam_monitor.sv
module drfam_monitor
  import drfam_pkg::*;
#(
  parameter int TICK_CYC   = TICK_CYCLES,
  parameter int BUS_MS     = BUS_TIMEOUT_MS,
  parameter int SETUP_MS   = SETUP_TIMEOUT_MS,
  parameter int LOSS_MS    = LINK_LOSS_MS,
  parameter int DIR_MS     = BOTH_DIR_MS,
  parameter int ERRSHOW_MS = WRITE_FAIL_SHOW_MS,
  parameter int CUR_W      = 12
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  input  wire logic              inhibit_cmd_i,
  input  wire logic              fwd_run_i,
  input  wire logic              rev_run_i,
  input  wire logic [EXT_N-1:0]  ext_trip_i,
  input  wire logic              host_trip_i,
  input  wire logic              plc_link_up_i,
  input  wire logic              ctrl_data_valid_i,
  input  wire logic              remote_link_up_i,
  input  wire logic              remote_link_err_i,
  input  wire logic              program_mode_i,
  input  wire logic              nvm_write_fail_i,
  input  wire logic [CUR_W-1:0]  ground_current_i,
  input  wire logic [CUR_W-1:0]  rated_current_i,
  input  wire logic              dc_fuse_open_i,
  input  wire logic [SELF_N-1:0] selftest_fail_i,
  input  wire logic              illegal_param_i,
  output logic                   drive_enable_o,
  output logic                   fault_relay_o,
  output logic                   fault_signal_o,
  output logic      [7:0]        display_code_o,
  output logic                   display_blink_o,
  output logic                   waiting_host_o,
  output logic                   irq_o
);
  localparam int TW    = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam int N_TMR = 5;
  localparam int T_BUS = 0;
  localparam int T_SET = 1;
  localparam int T_LOS = 2;
  localparam int T_DIR = 3;
  localparam int T_ERR = 4;
  localparam int PW    = CUR_W + 8;

  generate
    if (TICK_CYC < 1 || BUS_MS < 1 || SETUP_MS < 1 || LOSS_MS < 1 || DIR_MS < 1 ||
        ERRSHOW_MS < 1 || BUS_MS > 8190 || SETUP_MS > 8190 || LOSS_MS > 8190 ||
        DIR_MS > 8190 || ERRSHOW_MS > 8190 || CUR_W < 1 || CUR_W > 20) begin : g_bad
      $error("drfam_monitor: parameter out of range");
    end
  endgenerate

  // ************************************************************
  // Millisecond tick
  // ************************************************************
  logic [TW-1:0] tick_cnt;
  wire           tick = (tick_cnt == TW'(TICK_CYC - 1));

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || tick) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + TW'(1);
  end

  // ************************************************************
  // Supervision timers, counted in ticks and saturating
  // ************************************************************
  logic             link_ever;
  logic             wr_fail_show;
  logic [12:0]      tmr_cnt [N_TMR];
  logic [12:0]      tmr_lim [N_TMR];
  logic [N_TMR-1:0] tmr_run;
  logic [N_TMR-1:0] tmr_exp;

  // Strict limits add one tick; tick phase gives up to one tick of slack
  assign tmr_lim[T_BUS] = 13'(BUS_MS + 1);
  assign tmr_lim[T_SET] = 13'(SETUP_MS);
  assign tmr_lim[T_LOS] = 13'(LOSS_MS);
  assign tmr_lim[T_DIR] = 13'(DIR_MS + 1);
  assign tmr_lim[T_ERR] = 13'(ERRSHOW_MS);
  assign tmr_run[T_BUS] = plc_link_up_i && !ctrl_data_valid_i;
  assign tmr_run[T_SET] = !link_ever;
  assign tmr_run[T_LOS] = link_ever && remote_link_err_i;
  assign tmr_run[T_DIR] = fwd_run_i && rev_run_i;
  assign tmr_run[T_ERR] = wr_fail_show;

  generate
    for (genvar t = 0; t < N_TMR; t++) begin : g_tmr
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !tmr_run[t]) tmr_cnt[t] <= '0;
        else if (tick && tmr_cnt[t] < tmr_lim[t]) tmr_cnt[t] <= tmr_cnt[t] + 13'h1;
      end
      assign tmr_exp[t] = tmr_run[t] && (tmr_cnt[t] >= tmr_lim[t]);
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) link_ever <= 1'b0;
    else if (remote_link_up_i) link_ever <= 1'b1;
  end

  // Set wins over the end of the showing time
  wire wr_fail_evt = nvm_write_fail_i && program_mode_i;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) wr_fail_show <= 1'b0;
    else if (wr_fail_evt) wr_fail_show <= 1'b1;
    else if (tmr_exp[T_ERR]) wr_fail_show <= 1'b0;
  end

  // ************************************************************
  // Condition sorting
  // ************************************************************
  logic [31:0]      control;
  wire [EXT_N-1:0]  ext_cont = control[CTRL_CONT_LSB +: EXT_N];
  wire [PW-1:0]     gnd_scaled = PW'(ground_current_i) * PW'(100);
  wire [PW-1:0]     rated_scaled = PW'(rated_current_i) * PW'(GROUND_TRIP_PCT);
  wire              ground_trip = gnd_scaled > rated_scaled;
  wire [FAULT_N-1:0] fault_cond = {illegal_param_i,
                                   selftest_fail_i,
                                   tmr_exp[T_LOS],
                                   tmr_exp[T_SET],
                                   tmr_exp[T_BUS],
                                   ground_trip,
                                   dc_fuse_open_i,
                                   ext_trip_i & ~ext_cont,
                                   host_trip_i};
  wire [ALARM_N-1:0] alarm_cond = {ext_trip_i & ext_cont,
                                   wr_fail_show,
                                   tmr_exp[T_DIR],
                                   inhibit_cmd_i};
  wire              fault_any = |fault_cond;
  wire              alarm_any = |alarm_cond;

  logic [7:0] fault_code_tbl [FAULT_N];
  logic [7:0] alarm_code_tbl [ALARM_N];
  logic [7:0] fault_pick;
  logic [7:0] alarm_pick;

  assign fault_code_tbl[0]  = CODE_HOST_EXTERNAL_TRIP;
  assign fault_code_tbl[6]  = CODE_DC_LINK_PROTECTOR_OPEN;
  assign fault_code_tbl[7]  = CODE_GROUND_LEAK_TRIP;
  assign fault_code_tbl[8]  = CODE_CTRL_DATA_TIMEOUT;
  assign fault_code_tbl[9]  = CODE_LINK_SETUP_TIMEOUT;
  assign fault_code_tbl[10] = CODE_LINK_LOSS_FAULT;
  assign fault_code_tbl[20] = CODE_ILLEGAL_PARAM;
  assign alarm_code_tbl[0]  = CODE_OUTPUT_INHIBIT_ALARM;
  assign alarm_code_tbl[1]  = CODE_BOTH_DIRECTION_CMD;
  assign alarm_code_tbl[2]  = CODE_PARAM_WRITE_FAIL;

  generate
    for (genvar e = 0; e < EXT_N; e++) begin : g_ext
      assign fault_code_tbl[1 + e] = EXT_CODE[e];
      assign alarm_code_tbl[3 + e] = EXT_CODE[e];
    end
    for (genvar s = 0; s < SELF_N; s++) begin : g_self
      assign fault_code_tbl[11 + s] = SELF_CODE[s];
    end
  endgenerate

  // Lowest index wins, so externally caused trips show before self-checks
  always_comb begin
    fault_pick = CODE_NONE;
    alarm_pick = CODE_NONE;
    for (int i = FAULT_N - 1; i >= 0; i--) begin
      if (fault_cond[i]) fault_pick = fault_code_tbl[i];
    end
    for (int j = ALARM_N - 1; j >= 0; j--) begin
      if (alarm_cond[j]) alarm_pick = alarm_code_tbl[j];
    end
  end

  // ************************************************************
  // Fault latch and outputs
  // ************************************************************
  logic       fault_latched;
  logic [7:0] fault_code;
  logic       alarm_any_q;
  wire        ctrl_wr   = reg_wr_i && (reg_addr_i == REG_CONTROL);
  wire        reset_req = ctrl_wr && reg_wdata_i[CTRL_RESET_BIT];
  wire        trip      = !fault_latched && fault_any;
  wire        release_f = fault_latched && reset_req && !fault_any;
  wire        next_drive_en = !(fault_latched || trip) && !inhibit_cmd_i &&
                              !tmr_exp[T_DIR];

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fault_latched <= 1'b0;
      fault_code    <= CODE_NONE;
    end else if (trip) begin
      fault_latched <= 1'b1;
      fault_code    <= fault_pick;
    end else if (release_f) begin
      fault_latched <= 1'b0;
      fault_code    <= CODE_NONE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      drive_enable_o  <= 1'b0;
      fault_relay_o   <= 1'b0;
      fault_signal_o  <= 1'b0;
      display_code_o  <= CODE_NONE;
      display_blink_o <= 1'b0;
      waiting_host_o  <= 1'b1;
      alarm_any_q     <= 1'b0;
    end else begin
      drive_enable_o  <= next_drive_en;
      fault_relay_o   <= fault_latched || trip;
      fault_signal_o  <= fault_latched || trip;
      display_code_o  <= trip ? fault_pick : fault_latched ? fault_code : alarm_pick;
      display_blink_o <= !(fault_latched || trip) && alarm_any;
      waiting_host_o  <= !plc_link_up_i;
      alarm_any_q     <= alarm_any;
    end
  end

  // ************************************************************
  // Fault history, fed only by trips
  // ************************************************************
  logic [8*HIST_DEPTH-1:0] hist;

  drfam_history #(
    .DEPTH      (HIST_DEPTH)
  ) u_history (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .push_i     (trip),
    .code_i     (fault_pick),
    .hist_o     (hist)
  );

  // ************************************************************
  // Register slave and interrupt
  // ************************************************************
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] irq_en;
  wire [EV_W-1:0]  ev_set = {wr_fail_evt, alarm_any && !alarm_any_q, trip};
  wire [EV_W-1:0]  ev_clr = (reg_wr_i && reg_addr_i == REG_IRQ_CLEAR) ?
                            reg_wdata_i[EV_W-1:0] : '0;
  wire [31:0]      state_word = {13'h0, fault_latched, waiting_host_o, drive_enable_o,
                                 alarm_pick, fault_code};
  wire [31:0]      rd_mux = (reg_addr_i == REG_STATUS)     ? 32'(status) :
                            (reg_addr_i == REG_IRQ_ENABLE) ? 32'(irq_en) :
                            (reg_addr_i == REG_CONTROL)    ? {control[31:1], 1'b0} :
                            (reg_addr_i == REG_STATE)      ? state_word :
                            (reg_addr_i == REG_HISTORY)    ? 32'(hist) : 32'h0;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      status      <= '0;
      irq_en      <= '0;
      control     <= CONTROL_RST;
      reg_rdata_o <= 32'h0;
    end else begin
      // A new event in the clearing cycle survives the clear
      status      <= (status & ~ev_clr) | ev_set;
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
      if (reg_wr_i && reg_addr_i == REG_IRQ_ENABLE) irq_en <= reg_wdata_i[EV_W-1:0];
      if (ctrl_wr) control <= {23'h0, reg_wdata_i[CTRL_CONT_LSB +: EXT_N], 4'h0};
    end
  end

  assign irq_o = |(status & irq_en);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_alarm_runs: assert property (
    !fault_latched && !fault_any && !inhibit_cmd_i && !tmr_exp[T_DIR] ##1 !trip
    |-> drive_enable_o) else $error("drive stopped by an alarm");
  chk_alarm_unlogged: assert property (!trip |=> $stable(hist))
    else $error("history changed without a trip");
  chk_trip_outputs: assert property (trip |=> fault_relay_o && fault_signal_o &&
    !drive_enable_o && !display_blink_o && display_code_o == $past(fault_pick))
    else $error("trip outputs wrong");
  chk_inhibit_cut: assert property (inhibit_cmd_i && !fault_any && !fault_latched
    |=> !drive_enable_o && display_blink_o && display_code_o == CODE_OUTPUT_INHIBIT_ALARM)
    else $error("inhibit did not cut output");
  chk_bus_fresh: assert property (ctrl_data_valid_i |-> !tmr_exp[T_BUS])
    else $error("bus error with fresh data");
  chk_wait_host: assert property (!plc_link_up_i |=> waiting_host_o)
    else $error("waiting status missing");
  chk_setup_done: assert property (link_ever |-> !fault_cond[9])
    else $error("setup fault after link came up");
  chk_loss_guard: assert property (!link_ever |-> !fault_cond[10])
    else $error("link loss before first link");
  chk_dir_release: assert property (!(fwd_run_i && rev_run_i) |-> !tmr_exp[T_DIR])
    else $error("direction alarm without both commands");
  chk_latch_hold: assert property (fault_latched && !reset_req |=> fault_latched
    ##0 !drive_enable_o) else $error("fault released without reset");
  chk_irq_sticky: assert property (trip |=> status[EV_TRIP])
    else $error("trip event not recorded");
endmodule

// ### src/drfam_pkg.sv
package drfam_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ             = 200_000_000;
  localparam int TICK_TIME_US       = 1000;
  localparam int TICK_CYCLES        = CLK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int BUS_TIMEOUT_MS     = 2000;
  localparam int SETUP_TIMEOUT_MS   = 5000;
  localparam int LINK_LOSS_MS       = 2000;
  localparam int BOTH_DIR_MS        = 500;
  localparam int WRITE_FAIL_SHOW_MS = 1000;
  localparam int GROUND_TRIP_PCT    = 50;
  localparam int HIST_DEPTH         = 4;
  localparam int EXT_N              = 5;
  localparam int SELF_N             = 9;
  localparam int FAULT_N            = 21;
  localparam int ALARM_N            = 8;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0]  REG_STATUS     = 8'h00;
  localparam logic [7:0]  REG_IRQ_CLEAR  = 8'h04;
  localparam logic [7:0]  REG_IRQ_ENABLE = 8'h08;
  localparam logic [7:0]  REG_CONTROL    = 8'h0c;
  localparam logic [7:0]  REG_STATE      = 8'h10;
  localparam logic [7:0]  REG_HISTORY    = 8'h14;
  localparam int          EV_TRIP        = 0;
  localparam int          EV_ALARM       = 1;
  localparam int          EV_WRFAIL      = 2;
  localparam int          EV_W           = 3;
  localparam int          CTRL_RESET_BIT = 0;
  localparam int          CTRL_CONT_LSB  = 4;
  localparam logic [31:0] CONTROL_RST    = 32'h0000_0000;
  localparam int          ST_FAULT_LSB   = 0;
  localparam int          ST_ALARM_LSB   = 8;
  localparam int          ST_DRIVE_BIT   = 16;
  localparam int          ST_WAIT_BIT    = 17;
  localparam int          ST_LATCH_BIT   = 18;

  // ************************************************************
  // Display codes
  // ************************************************************
  localparam logic [7:0] CODE_NONE                   = 8'h00;
  localparam logic [7:0] CODE_OUTPUT_INHIBIT_ALARM   = 8'h01;
  localparam logic [7:0] CODE_BOTH_DIRECTION_CMD     = 8'h04;
  localparam logic [7:0] CODE_PARAM_WRITE_FAIL       = 8'h05;
  localparam logic [7:0] CODE_CTRL_DATA_TIMEOUT      = 8'h02;
  localparam logic [7:0] CODE_HOST_EXTERNAL_TRIP     = 8'h10;
  localparam logic [7:0] CODE_DC_LINK_PROTECTOR_OPEN = 8'h20;
  localparam logic [7:0] CODE_GROUND_LEAK_TRIP       = 8'h21;
  localparam logic [7:0] CODE_ILLEGAL_PARAM          = 8'h30;
  localparam logic [7:0] CODE_LINK_SETUP_TIMEOUT     = 8'h40;
  localparam logic [7:0] CODE_LINK_LOSS_FAULT        = 8'h41;
  localparam logic [3:0] CLASS_ILLEGAL               = 4'h3;
  localparam logic [3:0] CLASS_CTRL_LO               = 4'h4;
  localparam logic [3:0] CLASS_CTRL_HI               = 4'h5;
  localparam logic [7:0] EXT_CODE [EXT_N] = '{8'h13, 8'h15, 8'h16, 8'h17, 8'h18};
  // Inhibit circuit, SRAM, checksum, CPU converter, option connection,
  // option converter, option self-test, model mismatch, mutual check
  localparam logic [7:0] SELF_CODE [SELF_N] =
    '{8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h50, 8'h51, 8'h52, 8'h53};
endpackage

// ### src/drfam_history.sv
module drfam_history
  import drfam_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 push_i,
  input  wire logic [7:0]           code_i,
  output logic      [8*DEPTH-1:0]   hist_o
);
  logic [7:0] entry [DEPTH];

  // ************************************************************
  // Entry filter
  // ************************************************************
  wire excluded = (code_i[7:4] == CLASS_ILLEGAL) || (code_i[7:4] == CLASS_CTRL_LO) ||
                  (code_i[7:4] == CLASS_CTRL_HI);
  wire take     = push_i && !excluded && (code_i != entry[0]);

  // ************************************************************
  // Shift register, newest in entry 0
  // ************************************************************
  generate
    if (DEPTH < 1) begin : g_bad
      $error("drfam_history: DEPTH must be at least 1");
    end
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      if (i == 0) begin : g_head
        always_ff @(posedge core_clk_i) begin
          if (sys_rst_i) entry[i] <= CODE_NONE;
          else if (take) entry[i] <= code_i;
        end
      end else begin : g_tail
        always_ff @(posedge core_clk_i) begin
          if (sys_rst_i) entry[i] <= CODE_NONE;
          else if (take) entry[i] <= entry[i-1];
        end
      end
      assign hist_o[8*i +: 8] = entry[i];
    end
  endgenerate

  chk_hist_exclude: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    push_i && excluded |=> $stable(hist_o)) else $error("excluded code entered history");
  chk_hist_repeat: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    push_i && (code_i == hist_o[7:0]) |=> $stable(hist_o))
    else $error("repeated newest code entered again");
  chk_hist_push: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    push_i && !excluded && (code_i != hist_o[7:0]) |=> hist_o[7:0] == $past(code_i))
    else $error("tripping code not stored as newest");
endmodule

// ### sim/drfam_far_side.sv
module drfam_far_side (
  input  wire logic core_clk_i,
  input  wire logic plc_en_i,
  input  wire logic remote_en_i,
  input  wire logic data_en_i,
  input  wire logic err_en_i,
  output logic      plc_link_up_o,
  output logic      ctrl_data_valid_o,
  output logic      remote_link_up_o,
  output logic      remote_link_err_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Host, remote operator and link model
  // ************************************************************
  logic [2:0] gap;
  initial begin
    {gap, plc_link_up_o, ctrl_data_valid_o, remote_link_up_o, remote_link_err_o} = '0;
  end
  // Control data only every eighth cycle: slow, but well inside the testbench bus timeout of 6 ticks
  always @(posedge core_clk_i) begin
    gap               <= gap + 3'h1;
    plc_link_up_o     <= plc_en_i;
    ctrl_data_valid_o <= plc_en_i & data_en_i & (gap == 3'h0);
    remote_link_up_o  <= remote_en_i;
    remote_link_err_o <= err_en_i;
  end
endmodule

// ### sim/tb_drive_fault_alarm_monitor.sv
module tb_drive_fault_alarm_monitor
  import drfam_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, wr, rd, inh, fwd, rev, host, pm, nwf, fuse, ill, pe, re, de, ee;
  logic        plc, cdv, rup, rerr, den, rly, sig, blk, wt, irq;
  logic [7:0]  addr, code;
  logic [31:0] wd, rdat, v, hexp, r;
  logic [4:0]  ext, cont;
  logic [8:0]  self;
  logic [11:0] gnd, rat, one;
  int          num_errors, checked, cyc, seed, i, k;
  wire  [11:0] obs = {code, blk, den, rly, sig};

  drfam_monitor #(.TICK_CYC(4), .BUS_MS(5), .SETUP_MS(20), .LOSS_MS(5), .DIR_MS(3),
    .ERRSHOW_MS(4)) dut (
    .core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdat), .inhibit_cmd_i(inh), .fwd_run_i(fwd), .rev_run_i(rev),
    .ext_trip_i(ext), .host_trip_i(host), .plc_link_up_i(plc), .ctrl_data_valid_i(cdv),
    .remote_link_up_i(rup), .remote_link_err_i(rerr), .program_mode_i(pm),
    .nvm_write_fail_i(nwf), .ground_current_i(gnd), .rated_current_i(rat),
    .dc_fuse_open_i(fuse), .selftest_fail_i(self), .illegal_param_i(ill),
    .drive_enable_o(den), .fault_relay_o(rly), .fault_signal_o(sig), .display_code_o(code),
    .display_blink_o(blk), .waiting_host_o(wt), .irq_o(irq));
  drfam_far_side far (.core_clk_i(clk), .plc_en_i(pe), .remote_en_i(re), .data_en_i(de),
    .err_en_i(ee), .plc_link_up_o(plc), .ctrl_data_valid_o(cdv), .remote_link_up_o(rup),
    .remote_link_err_o(rerr));

  // ************************************************************
  // Checking and bus tasks
  // ************************************************************
  function automatic logic [11:0] ex(input logic [7:0] c, input logic b, e, f);
    return {c, b, e, f, f};
  endfunction
  function automatic logic [7:0] fcode(input int n);
    return n < 9 ? SELF_CODE[n] : n == 9 ? CODE_DC_LINK_PROTECTOR_OPEN
         : n == 10 ? CODE_HOST_EXTERNAL_TRIP : CODE_ILLEGAL_PARAM;
  endfunction
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Outputs are sampled mid-cycle so no edge race can decide the outcome
  task automatic look(input logic [11:0] e, input logic [1:0] a);
    @(negedge clk);
    chk(obs, e);
    chk({wt, irq}, a);
    @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdat;
    @(posedge clk);
  endtask
  task automatic hpush(input logic [7:0] c);
    if (!(c[7:4] inside {4'h3, 4'h4, 4'h5}) && c !== hexp[7:0]) hexp = {hexp[23:0], c};
  endtask
  task automatic trip(input logic [7:0] c);
    look(ex(c, 1'b0, 1'b0, 1'b1), 2'b00);
    hpush(c);
  endtask
  task automatic clear();
    tick(2);
    wreg(REG_CONTROL, {23'h0, cont, 4'h1});
    tick(1);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    {wr, rd, inh, fwd, rev, host, pm, nwf, fuse, ill, pe, re, de, ee} = '0;
    {addr, wd, hexp, ext, cont, self, gnd, one} = '0;
    rat = 12'h100;
    rst = 1'b1;
    seed = 91;
    tick(5);
    rst <= 1'b0;
    tick(2);
    look(ex(8'h00, 1'b0, 1'b1, 1'b0), 2'b10);
    wreg(REG_IRQ_ENABLE, 32'h1);
    rreg(REG_IRQ_ENABLE);
    chk(v, 32'h1);
    tick(85);
    look(ex(CODE_LINK_SETUP_TIMEOUT, 1'b0, 1'b0, 1'b1), 2'b11);
    pe <= 1'b1;
    re <= 1'b1;
    de <= 1'b1;
    wreg(REG_IRQ_CLEAR, 32'h1);
    wreg(REG_IRQ_ENABLE, 32'h0);
    clear();
    look(ex(8'h00, 1'b0, 1'b1, 1'b0), 2'b00);
    fuse <= 1'b1;
    tick(2);
    trip(CODE_DC_LINK_PROTECTOR_OPEN);
    clear();
    look(ex(CODE_DC_LINK_PROTECTOR_OPEN, 1'b0, 1'b0, 1'b1), 2'b00);
    rreg(REG_STATE);
    chk(v, (32'h1 << ST_LATCH_BIT) | 32'(CODE_DC_LINK_PROTECTOR_OPEN));
    fuse <= 1'b0;
    clear();
    wreg(REG_IRQ_ENABLE, 32'h1);
    look(ex(8'h00, 1'b0, 1'b1, 1'b0), 2'b01);
    rreg(REG_STATUS);
    chk(v, 32'h1);
    wreg(REG_IRQ_CLEAR, 32'h7);
    wreg(REG_IRQ_ENABLE, 32'h0);
    r = $random(seed);
    rat <= r[11:0] | 12'h1;
    gnd <= r[11:1];
    tick(3);
    look(ex(8'h00, 1'b0, 1'b1, 1'b0), 2'b00);
    gnd <= r[11:1] + 12'h1;
    tick(3);
    trip(CODE_GROUND_LEAK_TRIP);
    gnd <= '0;
    clear();
    for (i = 0; i < 12; i++) begin
      one = 12'h1 << i;
      self <= one[8:0];
      fuse <= one[9];
      host <= one[10];
      ill <= one[11];
      tick(3);
      trip(fcode(i));
      self <= '0;
      fuse <= 1'b0;
      host <= 1'b0;
      ill <= 1'b0;
      clear();
    end
    // Last two passes hit terminal a twice in stop mode: a repeat must not re-enter
    for (i = 0; i < 7; i++) begin
      k = (i < 5) ? i : 0;
      r = $random(seed);
      cont[k] = (i < 5) ? r[0] : 1'b0;
      wreg(REG_CONTROL, {23'h0, cont, 4'h0});
      ext <= 5'h1 << k;
      tick(3);
      if (cont[k]) begin
        look(ex(EXT_CODE[k], 1'b1, 1'b1, 1'b0), 2'b00);
      end else begin
        trip(EXT_CODE[k]);
      end
      ext <= '0;
      clear();
    end
    rreg(REG_HISTORY);
    chk(v, hexp);
    inh <= 1'b1;
    tick(2);
    look(ex(CODE_OUTPUT_INHIBIT_ALARM, 1'b1, 1'b0, 1'b0), 2'b00);
    inh <= 1'b0;
    fwd <= 1'b1;
    rev <= 1'b1;
    tick(2);
    look(ex(8'h00, 1'b0, 1'b1, 1'b0), 2'b00);
    tick(20);
    look(ex(CODE_BOTH_DIRECTION_CMD, 1'b1, 1'b0, 1'b0), 2'b00);
    rev <= 1'b0;
    pm <= 1'b1;
    nwf <= 1'b1;
    tick(1);
    nwf <= 1'b0;
    tick(1);
    look(ex(CODE_PARAM_WRITE_FAIL, 1'b1, 1'b1, 1'b0), 2'b00);
    rreg(REG_STATUS);
    chk(v, 32'h7);
    tick(25);
    look(ex(8'h00, 1'b0, 1'b1, 1'b0), 2'b00);
    de <= 1'b0;
    tick(40);
    trip(CODE_CTRL_DATA_TIMEOUT);
    de <= 1'b1;
    // Fresh data lands only every eighth cycle; let one arrive before reset
    tick(8);
    clear();
    ee <= 1'b1;
    tick(40);
    trip(CODE_LINK_LOSS_FAULT);
    ee <= 1'b0;
    clear();
    rreg(REG_HISTORY);
    chk(v, hexp);
    rreg(8'hfc);
    chk(v, 32'h0);
    report_and_stop();
  end
endmodule
